/* File: verilog/nva_access.sv */
// Register access over APB and the register addresses were decided locally.
`default_nettype none
module nva_access
	import nva_pkg::*;
#(
	parameter bit OPT_128K = 1'b0,
	parameter int SYS_HALF_CYC = OPT_128K ? SYS_HALF_CYC_128K : SYS_HALF_CYC_32K,
	parameter int WRITE_CYC = WRITE_CYC_DEF
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic sleep_mode,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	// strobe length in half periods for the built option
	localparam int STROBE_HALVES = OPT_128K ? STROBE_HALVES_128K : STROBE_HALVES_32K;
	// erase takes the first half of the write time
	localparam int ERASE_CYC = WRITE_CYC / 2;

	// whole block state
	typedef struct packed {
		nva_state_t st; // sequencer state
		logic page; // page_select
		logic dir; // direction_select
		logic idx4; // cell_index bit 4
		logic [3:0] idx_low; // nv_index_low
		logic [3:0] data_lo; // nv_data_low_nibble
		logic [3:0] data_hi; // nv_data_high_nibble
		nva_cnt_t cnt; // write timer
		nva_div_t div; // system clock half period divider
		logic [2:0] halves; // elapsed half periods of the strobe
		logic strobe; // read_strobe
		logic erase; // erase pulse
		logic prog; // program pulse
		logic stat; // write_done_request
		logic mask; // write_done_mask
		logic [31:0] prdata; // registered read data
	} nva_st_t;

	nva_st_t s_r;
	nva_st_t s_nxt;

	// link to the cell array
	nva_mem_if mem ();

	nva_cell_array u_cells (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.mem(mem)
	);

	// register access qualifiers
	logic apb_wr; // write access phase
	logic apb_rd_setup; // read setup phase
	logic busy; // write_in_progress
	logic half_tick; // one pulse per system clock half period

	// true for mapped offsets
	function automatic logic addr_ok(input logic [APB_AW-1:0] a);
		return a == REG_CONTROL || a == REG_INDEX_LOW || a == REG_DATA_LOW
			|| a == REG_DATA_HIGH || a == REG_IRQ_STATUS || a == REG_IRQ_MASK;
	endfunction

	// read mux, upper bits read as zero
	function automatic logic [31:0] rd_word(input logic [APB_AW-1:0] a);
		logic [3:0] v;
		v = 4'h0;
		case (a)
			REG_CONTROL: begin
				v[CTRL_PAGE_BIT] = s_r.page;
				v[CTRL_BUSY_BIT] = busy;
				v[CTRL_DIR_BIT] = s_r.dir;
				v[CTRL_IDX4_BIT] = s_r.idx4;
			end
			REG_INDEX_LOW: v = s_r.idx_low;
			REG_DATA_LOW: v = s_r.data_lo;
			REG_DATA_HIGH: v = s_r.data_hi;
			REG_IRQ_STATUS: v[IRQ_WDONE_BIT] = s_r.stat;
			REG_IRQ_MASK: v[IRQ_WDONE_BIT] = s_r.mask;
			default: v = 4'h0;
		endcase
		return {28'h0000000, v};
	endfunction

	// bus phase decode
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd_setup = psel && !penable && !pwrite;
	// both write phases count as busy
	assign busy = s_r.st == NVA_ERASE || s_r.st == NVA_PROG;
	assign half_tick = s_r.div == nva_div_t'(SYS_HALF_CYC - 1);

	// next state of registers, sequencer and interrupt
	always_comb begin
		s_nxt = s_r;
		s_nxt.erase = 1'b0;
		s_nxt.prog = 1'b0;
		// capture read data in the setup phase so it stands in the access phase
		if (apb_rd_setup) begin
			s_nxt.prdata = rd_word(paddr);
		end
		// register writes; memory registers are frozen while an access runs
		if (apb_wr && addr_ok(paddr)) begin
			case (paddr)
				REG_CONTROL: begin
					if (s_r.st == NVA_IDLE) begin
						s_nxt.page = pwdata[CTRL_PAGE_BIT];
						s_nxt.dir = pwdata[CTRL_DIR_BIT];
						s_nxt.idx4 = pwdata[CTRL_IDX4_BIT];
						if (pwdata[CTRL_DIR_BIT]) begin
							// write: erase starts at once, timer cleared
							s_nxt.st = NVA_ERASE;
							s_nxt.erase = 1'b1;
							s_nxt.cnt = '0;
						end else begin
							// read: strobe rises, divider restarts aligned
							s_nxt.st = NVA_READ;
							s_nxt.strobe = 1'b1;
							s_nxt.div = '0;
							s_nxt.halves = 3'd0;
						end
					end
				end
				REG_INDEX_LOW: begin
					if (s_r.st == NVA_IDLE) begin
						s_nxt.idx_low = pwdata[3:0];
					end
				end
				REG_DATA_LOW: begin
					if (s_r.st == NVA_IDLE) begin
						s_nxt.data_lo = pwdata[3:0];
					end
				end
				REG_DATA_HIGH: begin
					if (s_r.st == NVA_IDLE) begin
						s_nxt.data_hi = pwdata[3:0];
					end
				end
				REG_IRQ_STATUS: begin
					// write one to clear
					if (pwdata[IRQ_WDONE_BIT]) begin
						s_nxt.stat = 1'b0;
					end
				end
				REG_IRQ_MASK: begin
					s_nxt.mask = pwdata[IRQ_WDONE_BIT];
				end
				default: begin
				end
			endcase
		end
		// sequencer
		case (s_r.st)
			NVA_IDLE: begin
			end
			NVA_READ: begin
				// count system clock half periods of the strobe
				s_nxt.div = s_r.div + nva_div_t'(1);
				if (half_tick) begin
					s_nxt.div = '0;
					s_nxt.halves = s_r.halves + 3'd1;
					if (s_r.halves == 3'(STROBE_HALVES - 1)) begin
						// strobe ends; byte is taken at its trailing edge
						s_nxt.strobe = 1'b0;
						s_nxt.data_lo = mem.rdata[3:0];
						s_nxt.data_hi = mem.rdata[7:4];
						s_nxt.st = NVA_IDLE;
					end
				end
			end
			NVA_ERASE: begin
				// erase phase, then program phase
				s_nxt.cnt = s_r.cnt + nva_cnt_t'(1);
				if (s_r.cnt == nva_cnt_t'(ERASE_CYC - 1)) begin
					s_nxt.st = NVA_PROG;
				end
			end
			NVA_PROG: begin
				s_nxt.cnt = s_r.cnt + nva_cnt_t'(1);
				if (s_r.cnt == nva_cnt_t'(WRITE_CYC - 1)) begin
					// program the byte and flag completion
					s_nxt.prog = 1'b1;
					s_nxt.st = NVA_IDLE;
					s_nxt.stat = 1'b1;
				end
			end
			default: begin
				s_nxt.st = NVA_IDLE;
			end
		endcase
		// sleep cancels the access and its pulses; a done request or read byte due in the same cycle still lands, and an erased cell stays corrupted
		if (sleep_mode) begin
			s_nxt.st = NVA_IDLE;
			s_nxt.strobe = 1'b0;
			s_nxt.erase = 1'b0;
			s_nxt.prog = 1'b0;
		end
	end

	// state register; reset also cancels a write in flight
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_r <= '{
				st: NVA_IDLE,
				page: CTRL_BIT_RST,
				dir: CTRL_BIT_RST,
				idx4: CTRL_BIT_RST,
				idx_low: NIBBLE_RST,
				data_lo: NIBBLE_RST,
				data_hi: NIBBLE_RST,
				cnt: '0,
				div: '0,
				halves: 3'd0,
				strobe: 1'b0,
				erase: 1'b0,
				prog: 1'b0,
				stat: STAT_RST,
				mask: MASK_RST,
				prdata: 32'h00000000
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	// memory side: flat index with page on top
	assign mem.addr = {s_r.page, s_r.idx4, s_r.idx_low};
	assign mem.read_strobe = s_r.strobe;
	assign mem.erase_pulse = s_r.erase;
	assign mem.prog_pulse = s_r.prog;
	assign mem.wdata = {s_r.data_hi, s_r.data_lo};

	// bus answer: zero wait states, error on unmapped offsets
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok(paddr);
	assign prdata = s_r.prdata;
	// masked done request stays pending in status
	assign irq = s_r.stat && !s_r.mask;

	// lengths of the last strobe and write, for the checks below
	int slen_q;
	int wlen_q;
	logic wr_ctl;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			slen_q <= 0;
			wlen_q <= 0;
		end else begin
			slen_q <= s_r.strobe ? slen_q + 1 : 0;
			wlen_q <= busy ? wlen_q + 1 : 0;
		end
	end

	assign wr_ctl = apb_wr && paddr == REG_CONTROL && s_r.st == NVA_IDLE && !sleep_mode;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_flat_index: assert property (
		wr_ctl |=> mem.addr == {$past(pwdata[CTRL_PAGE_BIT]), $past(pwdata[CTRL_IDX4_BIT]), s_r.idx_low})
		else $error("flat index not formed from page and index");
	a_ctrl_launch: assert property (
		wr_ctl |=> s_r.st != NVA_IDLE)
		else $error("control write did not launch an access");
	a_dir_write: assert property (
		wr_ctl && pwdata[CTRL_DIR_BIT] |=> busy && !s_r.strobe && mem.erase_pulse)
		else $error("direction one did not start a write");
	a_dir_read: assert property (
		wr_ctl && !pwdata[CTRL_DIR_BIT] |=> s_r.strobe && !busy)
		else $error("direction zero did not start a read");
	a_read_data: assert property (
		$fell(s_r.strobe) && !$past(sleep_mode) |-> {s_r.data_hi, s_r.data_lo} == $past(mem.rdata))
		else $error("read byte not latched at strobe end");
	a_strobe_32k: assert property (
		$fell(s_r.strobe) && !$past(sleep_mode) && !OPT_128K
		|-> slen_q == STROBE_HALVES_32K * SYS_HALF_CYC)
		else $error("read strobe width wrong for 32k option");
	a_strobe_128k: assert property (
		$fell(s_r.strobe) && !$past(sleep_mode) && OPT_128K
		|-> slen_q == STROBE_HALVES_128K * SYS_HALF_CYC)
		else $error("read strobe width wrong for 128k option");
	a_data_nibbles: assert property (
		apb_rd_setup && paddr == REG_DATA_LOW |=> prdata == {28'h0000000, s_r.data_lo})
		else $error("low data register misread");
	// the program pulse stands in the first cycle in which busy is seen low
	a_write_time: assert property (
		$fell(busy) && !$past(sleep_mode) |-> wlen_q == WRITE_CYC && mem.prog_pulse)
		else $error("write did not last its full time");
	a_busy_read: assert property (
		apb_rd_setup && paddr == REG_CONTROL |=> prdata[CTRL_BUSY_BIT] == $past(busy))
		else $error("busy bit does not follow write state");
	a_done_req: assert property (
		$fell(busy) && !$past(sleep_mode) |-> s_r.stat)
		else $error("write end raised no request");
	a_mask_reset: assert property (
		$rose(rst_b) |-> s_r.mask && !irq)
		else $error("done request not masked after reset");
	a_irq_gate: assert property (
		irq |-> s_r.stat && !s_r.mask)
		else $error("interrupt raised while masked or idle");
	a_sleep_abort: assert property (
		sleep_mode |=> !busy && !s_r.strobe && !mem.prog_pulse)
		else $error("sleep did not abort the access");
	a_req_pending: assert property (
		s_r.stat && !(apb_wr && paddr == REG_IRQ_STATUS && pwdata[IRQ_WDONE_BIT]) |=> s_r.stat)
		else $error("done request dropped without clear");

	c_read_done: cover property ($fell(s_r.strobe) && !$past(sleep_mode));
	c_write_done: cover property ($fell(busy) && s_r.stat);
	c_write_abort: cover property (busy && sleep_mode);
	c_irq_raised: cover property ($rose(irq));
endmodule
`default_nettype wire

/* File: verilog/nva_pkg.sv */
`default_nettype none
// shared constants and types of the nonvolatile access block
package nva_pkg;
	// apb address width and register byte offsets
	localparam int APB_AW = 8;
	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_INDEX_LOW = 8'h04;
	localparam logic [7:0] REG_DATA_LOW = 8'h08;
	localparam logic [7:0] REG_DATA_HIGH = 8'h0C;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;
	// nv_control field positions
	localparam int CTRL_IDX4_BIT = 0;
	localparam int CTRL_DIR_BIT = 1;
	localparam int CTRL_BUSY_BIT = 2;
	localparam int CTRL_PAGE_BIT = 3;
	// interrupt status and mask field position
	localparam int IRQ_WDONE_BIT = 0;
	// reset values
	localparam logic [3:0] NIBBLE_RST = 4'h0;
	localparam logic CTRL_BIT_RST = 1'b0;
	localparam logic STAT_RST = 1'b0;
	localparam logic MASK_RST = 1'b1;
	// memory geometry
	localparam int IDX_W = 6;
	localparam int CELLS = 64;
	// core clock and system clock options
	localparam int CORE_CLK_HZ = 200_000_000;
	localparam int SYS_CLK_HZ_32K = 32_768;
	localparam int SYS_CLK_HZ_128K = 131_072;
	localparam int SYS_HALF_CYC_32K = CORE_CLK_HZ / (2 * SYS_CLK_HZ_32K);
	localparam int SYS_HALF_CYC_128K = CORE_CLK_HZ / (2 * SYS_CLK_HZ_128K);
	// read strobe width in system clock half periods (1.5 and 3.5 periods)
	localparam int STROBE_HALVES_32K = 3;
	localparam int STROBE_HALVES_128K = 7;
	// erase plus program time
	localparam int WRITE_TIME_MS = 24;
	localparam int WRITE_CYC_DEF = WRITE_TIME_MS * (CORE_CLK_HZ / 1000);
	// counter widths
	localparam int CNT_W = 23;
	localparam int DIV_W = 13;
	typedef logic [CNT_W-1:0] nva_cnt_t;
	typedef logic [DIV_W-1:0] nva_div_t;
	// access sequencer states
	typedef enum logic [1:0] {
		NVA_IDLE,
		NVA_READ,
		NVA_ERASE,
		NVA_PROG
	} nva_state_t;
endpackage
`default_nettype wire

/* File: verilog/nva_mem_if.sv */
`default_nettype none
// link between the access sequencer and the cell array
interface nva_mem_if;
	import nva_pkg::*;
	logic [IDX_W-1:0] addr; // flat cell index, page on top
	logic read_strobe; // read strobe, high for the whole read window
	logic erase_pulse; // one cycle, starts a write
	logic prog_pulse; // one cycle, finishes a write
	logic [7:0] wdata; // byte to program
	logic [7:0] rdata; // byte read back
	modport ctl (
		output addr, read_strobe, erase_pulse, prog_pulse, wdata,
		input rdata
	);
	modport arr (
		input addr, read_strobe, erase_pulse, prog_pulse, wdata,
		output rdata
	);
endinterface
`default_nettype wire

/* File: verilog/nva_cell_array.sv */
`default_nettype none
// 64 x 8 nonvolatile cell array
module nva_cell_array
	import nva_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	nva_mem_if.arr mem
);
	// cells and read register as one state word
	typedef struct packed {
		logic [CELLS-1:0][7:0] cells;
		logic [7:0] rdata;
	} nva_arr_st_t;

	nva_arr_st_t s_r;
	nva_arr_st_t s_nxt;

	// erase clears to all ones, program stores the byte, strobe samples
	always_comb begin
		s_nxt = s_r;
		if (mem.erase_pulse) begin
			s_nxt.cells[mem.addr] = 8'hFF;
		end
		if (mem.prog_pulse) begin
			s_nxt.cells[mem.addr] = mem.wdata;
		end
		if (mem.read_strobe) begin
			s_nxt.rdata = s_r.cells[mem.addr];
		end
	end

	// cells keep their contents across reset, being nonvolatile
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s_r.rdata <= 8'h00;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign mem.rdata = s_r.rdata;
endmodule
`default_nettype wire

/* File: testbench/nva_cpu_model.sv */
`default_nettype none
// cpu side requester: issues apb transfers on behalf of the bench
module nva_cpu_model (
	input wire logic core_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	// bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// one transfer: setup, access held until pready, release, one idle edge
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

/* File: testbench/peripheral_eeprom_access_tb_top.sv */
`default_nettype none
// bench top: cpu model drives the access block over apb
module peripheral_eeprom_access_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import nva_pkg::*;
	localparam int HALF = 4; // shortened system clock half period
	localparam int WCYC = 40; // shortened erase plus program time
	logic core_clk = 1'b0;
	logic rst_b = 1'b0; // reset held from time zero
	logic sleep_mode = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err;
	int fails = 0;
	int checks_done = 0;
	// bus of the second build, made with the 128k strobe option
	logic psel_f, penable_f, pwrite_f, pready_f, pslverr_f, irq_f;
	logic [7:0] paddr_f;
	logic [31:0] pwdata_f, prdata_f;
	// 200 MHz clock
	always #2.5 core_clk = ~core_clk;
	nva_access #(.OPT_128K(1'b0), .SYS_HALF_CYC(HALF), .WRITE_CYC(WCYC)) i_dut (
		.core_clk(core_clk), .rst_b(rst_b), .sleep_mode(sleep_mode), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	nva_cpu_model i_cpu (
		.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// second build: the wider read strobe is only reachable here
	nva_access #(.OPT_128K(1'b1), .SYS_HALF_CYC(HALF), .WRITE_CYC(WCYC)) i_dut_fast (
		.core_clk(core_clk), .rst_b(rst_b), .sleep_mode(sleep_mode), .psel(psel_f),
		.penable(penable_f), .pwrite(pwrite_f), .paddr(paddr_f), .pwdata(pwdata_f),
		.prdata(prdata_f), .pready(pready_f), .pslverr(pslverr_f), .irq(irq_f));
	nva_cpu_model i_cpu_fast (
		.core_clk(core_clk), .psel(psel_f), .penable(penable_f), .pwrite(pwrite_f),
		.paddr(paddr_f), .pwdata(pwdata_f), .prdata(prdata_f), .pready(pready_f), .pslverr(pslverr_f));
	// compare one value and count it
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_cpu.xfer(1'b1, a, d, rd, err);
	endtask
	// register read with expected value
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		i_cpu.xfer(1'b0, a, 32'h0, rd, err);
		chk(what, exp, rd);
	endtask
	// interrupt level once the last write has settled
	task automatic irq_chk(input logic e);
		@(posedge core_clk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	// 128k build: write a byte, change the low nibble, read back across the wider strobe
	task automatic fast_cell(input logic [5:0] idx, input logic [7:0] b);
		i_cpu_fast.xfer(1'b1, REG_INDEX_LOW, {28'h0, idx[3:0]}, rd, err);
		i_cpu_fast.xfer(1'b1, REG_DATA_LOW, {28'h0, b[3:0]}, rd, err);
		i_cpu_fast.xfer(1'b1, REG_DATA_HIGH, {28'h0, b[7:4]}, rd, err);
		i_cpu_fast.xfer(1'b1, REG_CONTROL, {28'h0, idx[5], 2'b01, idx[4]}, rd, err);
		repeat (WCYC + 2) @(posedge core_clk);
		i_cpu_fast.xfer(1'b1, REG_DATA_LOW, {28'h0, ~b[3:0]}, rd, err);
		i_cpu_fast.xfer(1'b1, REG_CONTROL, {28'h0, idx[5], 2'b00, idx[4]}, rd, err);
		repeat (STROBE_HALVES_128K * HALF - 3) @(posedge core_clk);
		i_cpu_fast.xfer(1'b0, REG_DATA_LOW, 32'h0, rd, err);
		chk("fast data low early", {28'h0, ~b[3:0]}, rd);
		i_cpu_fast.xfer(1'b0, REG_DATA_LOW, 32'h0, rd, err);
		chk("fast data low", {28'h0, b[3:0]}, rd);
		i_cpu_fast.xfer(1'b0, REG_DATA_HIGH, 32'h0, rd, err);
		chk("fast data high", {28'h0, b[7:4]}, rd);
		chk("fast irq", 32'h0, {31'h0, irq_f});
	endtask
	// load index and both nibbles, then launch a write
	task automatic cell_write(input logic [5:0] idx, input logic [7:0] b);
		wr(REG_DATA_HIGH, {28'h0, b[7:4]});
		wr(REG_INDEX_LOW, {28'h0, idx[3:0]});
		wr(REG_DATA_LOW, {28'h0, b[3:0]});
		wr(REG_CONTROL, {28'h0, idx[5], 1'b0, 1'b1, idx[4]});
	endtask
	// launch a read, see old data while the strobe runs, then the stored byte
	task automatic cell_read(input logic [5:0] idx, input logic [3:0] old_lo, input logic [7:0] b,
		input bit hi_first);
		wr(REG_INDEX_LOW, {28'h0, idx[3:0]});
		wr(REG_CONTROL, {28'h0, idx[5], 2'b00, idx[4]});
		repeat (STROBE_HALVES_32K * HALF - 3) @(posedge core_clk);
		rchk("data low early", REG_DATA_LOW, {28'h0, old_lo});
		if (hi_first) rchk("data high", REG_DATA_HIGH, {28'h0, b[7:4]});
		rchk("data low", REG_DATA_LOW, {28'h0, b[3:0]});
		rchk("data high", REG_DATA_HIGH, {28'h0, b[7:4]});
	endtask
	// wait out a write with the busy flag timed against the write length
	task automatic write_wait(input logic [5:0] idx);
		repeat (WCYC - 6) @(posedge core_clk);
		rchk("busy late", REG_CONTROL, {28'h0, idx[5], 2'b11, idx[4]});
		repeat (4) @(posedge core_clk);
		i_cpu.xfer(1'b0, REG_CONTROL, 32'h0, rd, err);
		chk("busy done", 32'h0, {31'h0, rd[CTRL_BUSY_BIT]});
	endtask
	// verdict and end of run
	task automatic end_of_test;
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 6; i++) begin
			rchk("reset value", 8'(4 * i), {31'h0, 8'(4 * i) == REG_IRQ_MASK});
		end
		irq_chk(1'b0);
		cell_write(6'h33, 8'hA5);
		write_wait(6'h33);
		rchk("done status", REG_IRQ_STATUS, 32'h1);
		irq_chk(1'b0);
		wr(REG_IRQ_MASK, 32'h0);
		irq_chk(1'b1);
		wr(REG_IRQ_STATUS, 32'h1);
		irq_chk(1'b0);
		cell_write(6'h13, 8'h3C);
		write_wait(6'h13);
		cell_read(6'h33, 4'hC, 8'hA5, 1'b0);
		cell_read(6'h13, 4'h5, 8'h3C, 1'b1);
		wr(REG_IRQ_STATUS, 32'h1);
		irq_chk(1'b0);
		// sleep in mid-write aborts without a done request
		cell_write(6'h01, 8'h77);
		repeat (5) @(posedge core_clk);
		sleep_mode <= 1'b1;
		repeat (2) @(posedge core_clk);
		sleep_mode <= 1'b0;
		rchk("sleep abort", REG_CONTROL, 32'h2);
		rchk("sleep status", REG_IRQ_STATUS, 32'h0);
		// reset in mid-write aborts and restores reset values
		cell_write(6'h02, 8'h11);
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		rchk("reset abort", REG_CONTROL, 32'h0);
		rchk("reset status", REG_IRQ_STATUS, 32'h0);
		rchk("reset mask", REG_IRQ_MASK, 32'h1);
		chk("slverr mapped", 32'h0, {31'h0, err});
		// unmapped place answers with zero and an error
		rchk("unmapped", 8'h18, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		// wider strobe of the 128k build
		fast_cell(6'h2A, 8'h5C);
		end_of_test();
	end
	// watchdog against a hang
	initial begin
		repeat (3000) @(posedge core_clk);
		fails++;
		end_of_test();
	end
endmodule
`default_nettype wire
